// File: icc_defines.svh
/*
  Offsets, field positions, reset values and counts for the input capture
  channels. Included by bare name from the channel bank design file only.
*/
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH

// Register index within one channel's pair of words
`define ICC_REG_CTRL      1'h0
`define ICC_REG_BUF       1'h1

// Control register field positions
`define ICC_SIDL_BIT      13
`define ICC_TMR_BIT       7
`define ICC_ICI_HI        6
`define ICC_ICI_LO        5
`define ICC_OV_BIT        4
`define ICC_BNE_BIT       3
`define ICC_MODE_HI       2
`define ICC_MODE_LO       0

// Reset value and writable-bit mask of the control register
`define ICC_CTRL_RESET    16'h0000
`define ICC_CTRL_WMASK    16'h20e7

// Prescaler terminal counts (4th and 16th rising edge)
`define ICC_PRESC4_LAST   4'h3
`define ICC_PRESC16_LAST  4'hf

// Buffer depth, channel count, DMA-capable channels
`define ICC_FIFO_DEPTH    4
`define ICC_NUM_CH        8
`define ICC_DMA_CHANNELS  2

`endif

// File: icc_pkg.sv
/*
  Types shared by the input capture design files.
  Assumes icc_defines.svh is on the include path.
*/
`default_nettype none
package icc_pkg;

  // Capture mode field encodings
  typedef enum logic [2:0] {
    ICC_MODE_OFF       = 3'h0,
    ICC_MODE_BOTH      = 3'h1,
    ICC_MODE_FALL      = 3'h2,
    ICC_MODE_RISE      = 3'h3,
    ICC_MODE_DIV4      = 3'h4,
    ICC_MODE_DIV16     = 3'h5,
    ICC_MODE_UNUSED    = 3'h6,
    ICC_MODE_WAKE_ONLY = 3'h7
  } icc_mode_e;

  typedef logic [15:0] icc_word_t;

endpackage
`default_nettype wire

// File: icc_edge_sync.sv
/*
  Two-flop synchroniser and edge detector for one capture pin.
  Assumes the pin is asynchronous to clk_in; outputs are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module icc_edge_sync (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  // Next values of the synchroniser chain
  always_comb begin
    next_meta = pin_in;
    next_sync = meta;
    next_prev = sync;
  end

  // Synchroniser and history flops
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // Edges seen on the settled level only
  assign rise_out = sync & ~prev;
  assign fall_out = ~sync & prev;

endmodule
`default_nettype wire

// File: icc_channels.sv
/*
  Bank of input capture channels: edge qualification, prescaler, timestamp
  buffer, interrupt interval counter, DMA request and wake-up pulse.
  Assumes timebase counts and cpu_idle_in/cpu_sleep_in come from logic on
  clk_in; capture pins are asynchronous and are synchronised here.
*/
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "icc_defines.svh"

// Contract
// - Each qualifying event stores the full 16-bit count of the chosen timebase.
// - Timebase select set picks timebase A, clear picks timebase B.
// - Mode 000 turns the channel off with no captures.
// - Mode 001 captures both edges and interrupts on every capture.
// - Mode 010 captures falling edges, mode 011 rising edges.
// - Mode 100 captures every 4th rising edge, mode 101 every 16th.
// - Mode 110 is unused and behaves as disabled.
// - Mode 111 gives rising-edge interrupts only in Sleep or Idle.
// - Interval field raises interrupt after 1, 2, 3 or 4 captures.
// - Captures go into a four-deep first-in first-out buffer.
// - Read-only overflow bit shows that a capture overflow occurred.
// - Read-only nonempty bit is one while unread values remain.
// - Stop-in-idle set halts the channel in Idle; clear keeps it running.
// - A capture pin event wakes the device from Sleep and Idle; here only an interrupt wakes it, and in Sleep only mode 111 does.
// - Only the first two channels request DMA; software then uses interval 00.
// - Up to eight independent channels, each with control, buffer and pin.
// - Unimplemented control bits ignore writes and read as zero.
module icc_channels #(
  parameter int NUM_CH = `ICC_NUM_CH,
  parameter int DEPTH  = `ICC_FIFO_DEPTH,
  parameter int CH_W   = 3
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic [CH_W:0]     addr_in,
  input  wire logic [15:0]       wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [15:0]            rdata_out,
  input  wire logic [NUM_CH-1:0] capture_pin_in,
  input  wire logic [15:0]       timebase_a_count_in,
  input  wire logic [15:0]       timebase_b_count_in,
  input  wire logic              cpu_idle_in,
  input  wire logic              cpu_sleep_in,
  output logic [NUM_CH-1:0]      capture_irq_out,
  output logic [`ICC_DMA_CHANNELS-1:0] dma_req_out,
  output logic                   wake_out
);

  localparam int PW = $clog2(DEPTH);

  icc_pkg::icc_word_t ctrl      [NUM_CH];
  icc_pkg::icc_word_t next_ctrl [NUM_CH];
  icc_pkg::icc_word_t fifo      [NUM_CH][DEPTH];
  icc_pkg::icc_word_t next_fifo [NUM_CH][DEPTH];
  logic [PW-1:0]      rd_ptr        [NUM_CH];
  logic [PW-1:0]      next_rd_ptr   [NUM_CH];
  logic [PW-1:0]      wr_ptr        [NUM_CH];
  logic [PW-1:0]      next_wr_ptr   [NUM_CH];
  logic [PW:0]        count         [NUM_CH];
  logic [PW:0]        next_count    [NUM_CH];
  logic [3:0]         presc         [NUM_CH];
  logic [3:0]         next_presc    [NUM_CH];
  logic [1:0]         icnt          [NUM_CH];
  logic [1:0]         next_icnt     [NUM_CH];
  logic [NUM_CH-1:0]  ovf;
  logic [NUM_CH-1:0]  next_ovf;
  logic [NUM_CH-1:0]  irq;
  logic [NUM_CH-1:0]  next_irq;
  logic [`ICC_DMA_CHANNELS-1:0] dma;
  logic [`ICC_DMA_CHANNELS-1:0] next_dma;
  logic               wake;
  logic               next_wake;
  logic [15:0]        rdata;
  logic [15:0]        next_rdata;
  logic [NUM_CH-1:0]  rise_w;
  logic [NUM_CH-1:0]  fall_w;
  logic [NUM_CH-1:0]  pick_w;
  logic [NUM_CH-1:0]  push_w;
  logic [NUM_CH-1:0]  pop_w;
  logic [NUM_CH-1:0]  dma_ok;

  // Address match for one channel's register
  function automatic logic reg_hit(input logic [CH_W:0] addr, input int ch, input logic sel);
    return (addr[CH_W:1] == CH_W'(ch)) && (addr[0] == sel);
  endfunction

  // Buffer pointer advance with wrap
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Control word as software sees it
  function automatic icc_pkg::icc_word_t ctrl_view(input icc_pkg::icc_word_t c,
                                                  input logic o, input logic ne);
    icc_pkg::icc_word_t v;
    v = c & `ICC_CTRL_WMASK;
    v[`ICC_OV_BIT]  = o;
    v[`ICC_BNE_BIT] = ne;
    return v;
  endfunction

  // One synchroniser per capture pin
  for (genvar g = 0; g < NUM_CH; g++) begin : g_pin
    icc_edge_sync u_sync (
      .clk_in   (clk_in),
      .srst_in  (srst_in),
      .pin_in   (capture_pin_in[g]),
      .rise_out (rise_w[g]),
      .fall_out (fall_w[g])
    );
  end

  // Next state of every channel and of the register port
  always_comb begin
    icc_pkg::icc_mode_e mode;
    logic               run;
    logic               sleepy;
    logic               wr_ctrl;
    logic               rd_ctrl;
    logic               rd_buf;
    logic               drained;
    mode        = icc_pkg::ICC_MODE_OFF;
    run         = 1'b0;
    sleepy      = cpu_sleep_in | cpu_idle_in;
    wr_ctrl     = 1'b0;
    rd_ctrl     = 1'b0;
    rd_buf      = 1'b0;
    drained     = 1'b0;
    next_ctrl   = ctrl;
    next_fifo   = fifo;
    next_rd_ptr = rd_ptr;
    next_wr_ptr = wr_ptr;
    next_count  = count;
    next_presc  = presc;
    next_icnt   = icnt;
    next_ovf    = ovf;
    next_irq    = '0;
    dma_ok      = '0;
    next_rdata  = 16'h0000;
    pick_w      = '0;
    push_w      = '0;
    pop_w       = '0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      mode    = icc_pkg::icc_mode_e'(ctrl[ch][`ICC_MODE_HI:`ICC_MODE_LO]);
      run     = ~cpu_sleep_in & ~(ctrl[ch][`ICC_SIDL_BIT] & cpu_idle_in);
      wr_ctrl = wr_in & reg_hit(addr_in, ch, `ICC_REG_CTRL);
      rd_ctrl = rd_in & reg_hit(addr_in, ch, `ICC_REG_CTRL);
      rd_buf  = rd_in & reg_hit(addr_in, ch, `ICC_REG_BUF);
      // Edge qualification per mode
      case (mode)
        icc_pkg::ICC_MODE_BOTH: pick_w[ch] = run & (rise_w[ch] | fall_w[ch]);
        icc_pkg::ICC_MODE_FALL: pick_w[ch] = run & fall_w[ch];
        icc_pkg::ICC_MODE_RISE: pick_w[ch] = run & rise_w[ch];
        icc_pkg::ICC_MODE_DIV4, icc_pkg::ICC_MODE_DIV16: begin
          if (run & rise_w[ch]) begin
            if (presc[ch] == ((mode == icc_pkg::ICC_MODE_DIV4) ? `ICC_PRESC4_LAST
                                                               : `ICC_PRESC16_LAST)) begin
              pick_w[ch]     = 1'b1;
              next_presc[ch] = 4'h0;
            end else begin
              next_presc[ch] = presc[ch] + 4'h1;
            end
          end
        end
        default: begin
          // Off, unused and wake-only modes capture nothing
          pick_w[ch]     = 1'b0;
          next_presc[ch] = 4'h0;
        end
      endcase
      // Buffer pop and push; a pop frees room in the same cycle
      pop_w[ch]  = rd_buf & (count[ch] != '0);
      push_w[ch] = pick_w[ch] & ((count[ch] != (PW+1)'(DEPTH)) | pop_w[ch]);
      if (pop_w[ch]) begin
        next_rd_ptr[ch] = ptr_inc(rd_ptr[ch]);
      end
      if (push_w[ch]) begin
        next_fifo[ch][wr_ptr[ch]] = ctrl[ch][`ICC_TMR_BIT] ? timebase_a_count_in
                                                           : timebase_b_count_in;
        next_wr_ptr[ch] = ptr_inc(wr_ptr[ch]);
      end
      next_count[ch] = count[ch] + (PW+1)'(push_w[ch]) - (PW+1)'(pop_w[ch]);
      // Overflow: a dropped capture sets it, drain or off clears it, set wins
      drained = (pop_w[ch] & (count[ch] == (PW+1)'(1)) & ~push_w[ch]) |
                (mode == icc_pkg::ICC_MODE_OFF);
      next_ovf[ch] = (ovf[ch] & ~drained) | (pick_w[ch] & ~push_w[ch]);
      // Interrupt generation
      if (mode == icc_pkg::ICC_MODE_WAKE_ONLY) begin
        next_irq[ch]  = rise_w[ch] & sleepy;
        next_icnt[ch] = 2'h0;
      end else if (mode == icc_pkg::ICC_MODE_BOTH) begin
        next_irq[ch]  = pick_w[ch];
        next_icnt[ch] = 2'h0;
      end else if (pick_w[ch]) begin
        if (icnt[ch] == ctrl[ch][`ICC_ICI_HI:`ICC_ICI_LO]) begin
          next_irq[ch]  = 1'b1;
          next_icnt[ch] = 2'h0;
        end else begin
          next_icnt[ch] = icnt[ch] + 2'h1;
        end
      end else if (mode == icc_pkg::ICC_MODE_OFF || mode == icc_pkg::ICC_MODE_UNUSED) begin
        next_icnt[ch] = 2'h0;
      end
      // DMA requests from the first channels only
      dma_ok[ch] = next_irq[ch] & (mode != icc_pkg::ICC_MODE_WAKE_ONLY);
      // Control write; reserved bits are masked away
      if (wr_ctrl) begin
        next_ctrl[ch] = wdata_in & `ICC_CTRL_WMASK;
        if (wdata_in[`ICC_MODE_HI:`ICC_MODE_LO] != ctrl[ch][`ICC_MODE_HI:`ICC_MODE_LO]) begin
          next_presc[ch] = 4'h0;
          next_icnt[ch]  = 2'h0;
        end
      end
      // Read data for the next cycle
      if (rd_ctrl) begin
        next_rdata = ctrl_view(ctrl[ch], ovf[ch], count[ch] != '0);
      end else if (rd_buf && count[ch] != '0) begin
        next_rdata = fifo[ch][rd_ptr[ch]];
      end
    end
    next_dma  = dma_ok[`ICC_DMA_CHANNELS-1:0];
    next_wake = (|next_irq) & sleepy;
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        ctrl[ch]   <= `ICC_CTRL_RESET;
        rd_ptr[ch] <= '0;
        wr_ptr[ch] <= '0;
        count[ch]  <= '0;
        presc[ch]  <= 4'h0;
        icnt[ch]   <= 2'h0;
        for (int e = 0; e < DEPTH; e++) begin
          fifo[ch][e] <= 16'h0000;
        end
      end
      ovf   <= '0;
      irq   <= '0;
      dma   <= '0;
      wake  <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      ctrl   <= next_ctrl;
      fifo   <= next_fifo;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      count  <= next_count;
      presc  <= next_presc;
      icnt   <= next_icnt;
      ovf    <= next_ovf;
      irq    <= next_irq;
      dma    <= next_dma;
      wake   <= next_wake;
      rdata  <= next_rdata;
    end
  end

  // Registered outputs
  assign rdata_out       = rdata;
  assign capture_irq_out = irq;
  assign dma_req_out     = dma;
  assign wake_out        = wake;

  // Checks on channel 0
  logic [2:0] m0;
  assign m0 = ctrl[0][`ICC_MODE_HI:`ICC_MODE_LO];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_ctrl_read;
    rd_in && reg_hit(addr_in, 0, `ICC_REG_CTRL);
  endsequence

  sequence s_buf_read;
    rd_in && reg_hit(addr_in, 0, `ICC_REG_BUF) && count[0] != '0;
  endsequence

  property p_stamp;
    push_w[0] |=> fifo[0][$past(wr_ptr[0])] ==
      ($past(ctrl[0][`ICC_TMR_BIT]) ? $past(timebase_a_count_in) : $past(timebase_b_count_in));
  endproperty
  a_stamp: assert property (p_stamp) else $error("Captured value is not the selected timebase");

  property p_off;
    (m0 == 3'h0 || m0 == 3'h6 || m0 == 3'h7) |-> !pick_w[0];
  endproperty
  a_off: assert property (p_off) else $error("Capture while disabled or wake-only");

  property p_fall;
    (m0 == 3'h2 && pick_w[0]) |-> fall_w[0] && !rise_w[0];
  endproperty
  a_fall: assert property (p_fall) else $error("Falling mode captured a non-falling edge");

  property p_div4;
    (m0 == 3'h4 && pick_w[0]) |-> presc[0] == 4'h3 && rise_w[0];
  endproperty
  a_div4: assert property (p_div4) else $error("Divide-by-4 capture off its fourth edge");

  property p_interval;
    irq[0] |-> ($past(m0) == 3'h1 || $past(m0) == 3'h7 ||
                $past(icnt[0]) == $past(ctrl[0][`ICC_ICI_HI:`ICC_ICI_LO]));
  endproperty
  a_interval: assert property (p_interval) else $error("Interrupt off the programmed interval");

  property p_overflow;
    (pick_w[0] && count[0] == 3'h4 && !pop_w[0]) |=> ovf[0] && count[0] == 3'h4;
  endproperty
  a_overflow: assert property (p_overflow) else $error("Full buffer capture did not flag overflow");

  property p_nonempty;
    s_ctrl_read |=> rdata_out[`ICC_BNE_BIT] == ($past(count[0]) != '0) &&
                    rdata_out[15:14] == 2'h0 && rdata_out[12:8] == 5'h00;
  endproperty
  a_nonempty: assert property (p_nonempty) else $error("Control readback status wrong");

  property p_oldest;
    s_buf_read |=> rdata_out == $past(fifo[0][rd_ptr[0]]) ##1 ($past(rd_in) || rdata_out == 16'h0000);
  endproperty
  a_oldest: assert property (p_oldest) else $error("Buffer read did not return oldest value");

  property p_idle_halt;
    (ctrl[0][`ICC_SIDL_BIT] && cpu_idle_in) |-> !pick_w[0];
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("Capture while halted in idle");

endmodule
`default_nettype wire

// File: icc_pin_model.sv
/*
  Signal source model for the capture pins.
  Assumes the bench calls drive() just after a rising edge of clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module icc_pin_model (
  input  wire logic       clk_in,
  output logic      [7:0] pin_out
);
  // Pins rest low until the bench moves one
  initial begin
    pin_out = 8'h00;
  end

  // Moves one pin on the clock edge, then holds it for eight clocks
  task automatic drive(input int ch, input logic lvl);
    pin_out[ch] <= lvl;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// File: input_capture_channel_tb_top.sv
/*
  Self-checking bench for the capture channel bank, table driven.
  Assumes icc_defines.svh is on the include path and the pin model is compiled.
*/
`timescale 1ns/1ns
`default_nettype none
module input_capture_channel_tb_top;
  typedef struct {
    logic [2:0] ch;
    logic [2:0] mode;
    logic       ts;
    logic [1:0] iv;
    logic       sidl;
    logic       idle;
    logic       sleep;
    int         np;
  } icc_row_s;

  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        idle = 1'b0;
  logic        sleep = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic [15:0] tba = 16'h0000;
  logic [15:0] tbb = 16'h0000;
  logic [15:0] rdata_out;
  logic [7:0]  pins;
  logic [7:0]  irq;
  logic [1:0]  dma;
  logic        wake;
  int          errors = 0;
  int          checks = 0;
  int          cur_ch = 0;
  int          n_irq, n_dma, n_wake, n_other;

  // ch mode ts iv sidl idle sleep pulses
  icc_row_s rows [14] = '{
    '{3'h0, 3'h3, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 3},
    '{3'h0, 3'h2, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 4},
    '{3'h0, 3'h1, 1'b1, 2'h3, 1'b0, 1'b0, 1'b0, 3},
    '{3'h5, 3'h1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 4},
    '{3'h0, 3'h4, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 8},
    '{3'h1, 3'h5, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 16},
    '{3'h0, 3'h0, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 3},
    '{3'h0, 3'h6, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 3},
    '{3'h2, 3'h3, 1'b1, 2'h2, 1'b0, 1'b0, 1'b0, 3},
    '{3'h0, 3'h3, 1'b1, 2'h0, 1'b1, 1'b1, 1'b0, 2},
    '{3'h3, 3'h3, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 2},
    '{3'h7, 3'h7, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 3},
    '{3'h6, 3'h7, 1'b1, 2'h0, 1'b0, 1'b0, 1'b0, 3},
    '{3'h4, 3'h3, 1'b1, 2'h0, 1'b0, 1'b0, 1'b1, 2}
  };

  // Clock, 40 ns period
  always #20 clk_in = ~clk_in;

  icc_channels i_dut (
    .clk_in              (clk_in),
    .srst_in             (srst_in),
    .addr_in             (addr_in),
    .wdata_in            (wdata_in),
    .wr_in               (wr_in),
    .rd_in               (rd_in),
    .rdata_out           (rdata_out),
    .capture_pin_in      (pins),
    .timebase_a_count_in (tba),
    .timebase_b_count_in (tbb),
    .cpu_idle_in         (idle),
    .cpu_sleep_in        (sleep),
    .capture_irq_out     (irq),
    .dma_req_out         (dma),
    .wake_out            (wake)
  );

  icc_pin_model u_pin (
    .clk_in  (clk_in),
    .pin_out (pins)
  );

  // Counts output pulses of the channel under test and strays
  always @(posedge clk_in) begin
    if (irq[cur_ch] === 1'b1) n_irq++;
    if (cur_ch < 2 && dma[cur_ch[0]] === 1'b1) n_dma++;
    if ((irq & ~(8'h01 << cur_ch)) !== 8'h00) n_other++;
    if (wake === 1'b1) n_wake++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    v = rdata_out;
  endtask

  // Loads distinct timebase values, then moves the pin
  task automatic edge_ev(input logic [2:0] ch, input logic lvl, input int ei);
    @(posedge clk_in);
    tba <= 16'ha000 + 16'(ei);
    tbb <= 16'h5000 + 16'(ei);
    u_pin.drive(int'(ch), lvl);
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the expected run of some 1400 cycles
  initial begin
    #800000;
    errors++;
    close_out();
  end

  // Table loop, then register and reset cases
  initial begin
    icc_row_s    r;
    logic [15:0] q[$];
    logic [15:0] v;
    logic        ov;
    logic        qual;
    int          nq, pc, ei, e_irq;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (rows[i]) begin
      r = rows[i];
      cur_ch = int'(r.ch);
      idle <= r.idle;
      sleep <= r.sleep;
      wr({r.ch, 1'b0}, {2'b00, r.sidl, 5'h00, r.ts, r.iv, 2'b00, r.mode});
      n_irq = 0;
      n_dma = 0;
      n_wake = 0;
      n_other = 0;
      q = {};
      nq = 0;
      pc = 0;
      ov = 1'b0;
      for (int k = 0; k < r.np; k++) begin
        for (int e = 0; e < 2; e++) begin
          ei = 2 * k + e;
          edge_ev(r.ch, e == 0, ei);
          qual = 1'b0;
          if (!(r.sleep || (r.sidl && r.idle))) begin
            case (r.mode)
              3'h1: qual = 1'b1;
              3'h2: qual = (e == 1);
              3'h3: qual = (e == 0);
              3'h4, 3'h5: if (e == 0) begin
                pc++;
                qual = (pc % ((r.mode == 3'h4) ? 4 : 16) == 0);
              end
              default: qual = 1'b0;
            endcase
          end
          if (qual) begin
            nq++;
            if (q.size() < 4) q.push_back(r.ts ? 16'ha000 + 16'(ei) : 16'h5000 + 16'(ei));
            else ov = 1'b1;
          end
        end
      end
      repeat (6) @(posedge clk_in);
      e_irq = (r.mode == 3'h7) ? ((r.idle || r.sleep) ? r.np : 0) : (r.mode == 3'h1) ? nq : nq / (int'(r.iv) + 1);
      chk(16'(n_irq), 16'(e_irq));
      chk(16'(n_other), 16'h0000);
      if (r.ch < 3'h2) chk(16'(n_dma), 16'((r.mode == 3'h7) ? 0 : e_irq));
      chk(16'(n_wake), 16'((r.idle || r.sleep) ? e_irq : 0));
      rd({r.ch, 1'b0}, v);
      chk(v, {2'b00, r.sidl, 5'h00, r.ts, r.iv, ov, q.size() > 0, r.mode});
      foreach (q[j]) begin
        rd({r.ch, 1'b1}, v);
        chk(v, q[j]);
      end
      rd({r.ch, 1'b1}, v);
      chk(v, 16'h0000);
      rd({r.ch, 1'b0}, v);
      chk(v, {2'b00, r.sidl, 5'h00, r.ts, r.iv, 2'b00, r.mode});
      wr({r.ch, 1'b0}, 16'h0000);
    end
    idle <= 1'b0;
    sleep <= 1'b0;
    // Writable bits, ignored buffer write, read data for one cycle only
    wr(4'h2, 16'hffff);
    rd(4'h2, v);
    chk(v, 16'h20e7);
    wr(4'h3, 16'h1234);
    rd(4'h3, v);
    chk(v, 16'h0000);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0003);
    rd(4'h0, v);
    chk(v, 16'h0003);
    @(negedge clk_in);
    chk(rdata_out, 16'h0000);
    // Reset in mid-run with a capture held
    cur_ch = 0;
    edge_ev(3'h0, 1'b1, 40);
    edge_ev(3'h0, 1'b0, 41);
    rd(4'h0, v);
    chk(v, 16'h000b);
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'b0;
    rd(4'h0, v);
    chk(v, 16'h0000);
    rd(4'h1, v);
    chk(v, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
